// *** ips_priority_regs.sv ***
// priority level registers with avalon slave and per-source level outputs
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module ips_priority_regs
  import ips_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // hardware standby pin, active low, asynchronous to clock
  input  wire logic              hwStandbyN,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // per-source priority levels for the arbiter
  output logic      [5:0]        prioExtLines,
  output logic                   prioWatchdog,
  output logic                   prioRefresh,
  output logic      [4:0]        prioTimerCh,
  output logic      [1:0]        prioDmaCh,
  output logic      [1:0]        prioSerialCh,
  output logic                   prioAdc
);

  // storage and bus state
  logic [PRIO_W-1:0] interruptPriorityA_reg;  // first priority register
  logic [PRIO_W-1:0] interruptPriorityB_reg;  // second priority register
  logic [31:0]       readdata_reg;            // captured read answer
  logic              ack_reg;                 // answer cycle marker
  logic              waitrequest_reg;         // registered waitrequest, high when idle
  logic              standbyMeta_reg;         // synchroniser stage one
  logic              standbySync_reg;         // synchroniser stage two, active high

  // decode and selection
  wire               hitA      = (address == PRIO_A_ADDR);
  wire               hitB      = (address == PRIO_B_ADDR);
  wire               lane0     = byteenable[0];
  // writes commit only on the edge where waitrequest is seen low
  wire               writeFire = write & ack_reg & lane0;
  wire               writeA    = writeFire & hitA;
  wire               writeB    = writeFire & hitB;
  // unmapped addresses read as zero, writes to them are dropped
  wire [PRIO_W-1:0]  readSel   = hitA ? interruptPriorityA_reg :
                                 hitB ? interruptPriorityB_reg : PRIO_RESET;
  wire               request   = read | write;
  wire               ack_next  = request & ~ack_reg;
  // spare positions of b, used to spot writes that touch only them
  wire [PRIO_W-1:0]  spareMaskB = (8'h01 << PRIO_B_SPARE_HI_BIT) |
                                  (8'h01 << PRIO_B_SPARE_LO_BIT);
  // a write to b whose non-spare bits equal what b already holds
  wire               onlySpareB = writeB &
                                  (((writedata[PRIO_W-1:0] ^ interruptPriorityB_reg) & ~spareMaskB)
                                   == 8'h00);
  // every level output in one word, for the checks below
  wire [17:0]        allLevels  = {prioExtLines, prioWatchdog, prioRefresh, prioTimerCh,
                                   prioDmaCh, prioSerialCh, prioAdc};

  // standby pin passes two flops before anything looks at it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      standbyMeta_reg <= 1'h0;
      standbySync_reg <= 1'h0;
    end else begin
      standbyMeta_reg <= ~hwStandbyN;
      standbySync_reg <= standbyMeta_reg;
    end
  end

  // bus handshake: one wait cycle, then a single answer cycle
  // waitrequest is held high in reset so no request is taken early
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_reg      <= 1'h0;
      waitrequest_reg <= 1'h1;
      readdata_reg <= 32'h00000000;
    end else begin
      ack_reg      <= ack_next;
      // own flop so the output leaves a register with no gate behind it
      waitrequest_reg <= ~ack_next;
      // read value sampled in the wait cycle, stands in the answer cycle
      if (read && !ack_reg) begin
        readdata_reg <= {READ_PAD, readSel};
      end
    end
  end

  // first priority register; standby overrides any write in flight
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interruptPriorityA_reg <= PRIO_RESET;
    end else if (standbySync_reg) begin
      interruptPriorityA_reg <= PRIO_RESET;
    end else if (writeA) begin
      interruptPriorityA_reg <= writedata[PRIO_W-1:0];
    end
  end

  // second priority register; spare bits stored like the rest
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interruptPriorityB_reg <= PRIO_RESET;
    end else if (standbySync_reg) begin
      interruptPriorityB_reg <= PRIO_RESET;
    end else if (writeB) begin
      interruptPriorityB_reg <= writedata[PRIO_W-1:0];
    end
  end

  // bus outputs straight from flops
  assign readdata    = readdata_reg;
  assign waitrequest = waitrequest_reg;

  // fan-out of register bits to sources; a 1 means priority level
  // shared bits drive every member of their group identically
  assign prioExtLines[0] = interruptPriorityA_reg[PRIO_EXT_LINE0_BIT];
  assign prioExtLines[1] = interruptPriorityA_reg[PRIO_EXT_LINE1_BIT];
  assign prioExtLines[2] = interruptPriorityA_reg[PRIO_EXT_LINES2_3_BIT];
  assign prioExtLines[3] = interruptPriorityA_reg[PRIO_EXT_LINES2_3_BIT];
  assign prioExtLines[4] = interruptPriorityA_reg[PRIO_EXT_LINES4_5_BIT];
  assign prioExtLines[5] = interruptPriorityA_reg[PRIO_EXT_LINES4_5_BIT];
  assign prioWatchdog    = interruptPriorityA_reg[PRIO_WATCHDOG_REFRESH_BIT];
  assign prioRefresh     = interruptPriorityA_reg[PRIO_WATCHDOG_REFRESH_BIT];
  assign prioTimerCh[0]  = interruptPriorityA_reg[PRIO_TIMER_CH0_BIT];
  assign prioTimerCh[1]  = interruptPriorityA_reg[PRIO_TIMER_CH1_BIT];
  assign prioTimerCh[2]  = interruptPriorityA_reg[PRIO_TIMER_CH2_BIT];
  assign prioTimerCh[3]  = interruptPriorityB_reg[PRIO_TIMER_CH3_BIT];
  assign prioTimerCh[4]  = interruptPriorityB_reg[PRIO_TIMER_CH4_BIT];
  assign prioDmaCh[0]    = interruptPriorityB_reg[PRIO_DMA_CH0_1_BIT];
  assign prioDmaCh[1]    = interruptPriorityB_reg[PRIO_DMA_CH0_1_BIT];
  assign prioSerialCh[0] = interruptPriorityB_reg[PRIO_SERIAL_CH0_BIT];
  assign prioSerialCh[1] = interruptPriorityB_reg[PRIO_SERIAL_CH1_BIT];
  assign prioAdc         = interruptPriorityB_reg[PRIO_ADC_BIT];

  // standby held for a cycle leaves register a at zero
  a_standby_clears_a: assert property (
    @(posedge clock) disable iff (!rstn)
    standbySync_reg |=> (interruptPriorityA_reg == PRIO_RESET))
    else $error("register a not cleared in standby");

  // standby held for a cycle leaves register b at zero
  a_standby_clears_b: assert property (
    @(posedge clock) disable iff (!rstn)
    standbySync_reg |=> (interruptPriorityB_reg == PRIO_RESET))
    else $error("register b not cleared in standby");

  // a committed write to a lands all eight bits
  a_write_lands_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (write && !waitrequest && hitA && lane0 && !standbySync_reg)
      |=> (interruptPriorityA_reg == $past(writedata[7:0])))
    else $error("write to register a lost");

  // a committed write to b keeps spare bits too
  a_write_spare_b: assert property (
    @(posedge clock) disable iff (!rstn)
    (write && !waitrequest && hitB && lane0 && !standbySync_reg)
      |=> (interruptPriorityB_reg[PRIO_B_SPARE_HI_BIT] == $past(writedata[4]))
       && (interruptPriorityB_reg[PRIO_B_SPARE_LO_BIT] == $past(writedata[0])))
    else $error("spare bits of register b not stored");

  // read answer carries the register as it was in the wait cycle
  a_read_back_b: assert property (
    @(posedge clock) disable iff (!rstn)
    (read && waitrequest && hitB)
      |=> !waitrequest && (readdata == {READ_PAD, $past(interruptPriorityB_reg)}))
    else $error("read of register b wrong");

  // without a write or standby the register holds
  a_hold_without_write: assert property (
    @(posedge clock) disable iff (!rstn)
    (!writeA && !standbySync_reg) |=> $stable(interruptPriorityA_reg))
    else $error("register a changed on its own");

  // grouped external lines always share their level
  a_ext_pairs_match: assert property (
    @(posedge clock) disable iff (!rstn)
    (prioExtLines[2] == prioExtLines[3]) && (prioExtLines[4] == prioExtLines[5])
      && (prioExtLines[4] == interruptPriorityA_reg[PRIO_EXT_LINES4_5_BIT]))
    else $error("external line groups disagree");

  // a write of bit 7 of b shows on timer channel 3 next cycle
  a_timer3_follows: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeB && !standbySync_reg) |=> (prioTimerCh[3] == $past(writedata[7])))
    else $error("timer channel 3 level wrong");

  // the answer cycle lasts one cycle only
  a_single_answer: assert property (
    @(posedge clock) disable iff (!rstn)
    !waitrequest |=> waitrequest)
    else $error("answer cycle longer than one");

  // bus and storage checks; waitrequest mirrors ack_reg inverted, so
  // a request seen with waitrequest high is the wait cycle of that request

  // a request seen with waitrequest high is answered at the next edge
  a_one_wait_cycle: assert property (
    @(posedge clock) disable iff (!rstn)
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("request not answered after one wait cycle");

  // with no request the slave keeps waitrequest high
  a_idle_keeps_wait: assert property (
    @(posedge clock) disable iff (!rstn)
    (!read && !write) |=> waitrequest)
    else $error("answer given without a request");

  // read data move only in the wait cycle of a read
  a_readdata_holds: assert property (
    @(posedge clock) disable iff (!rstn)
    !(read && waitrequest) |=> $stable(readdata))
    else $error("read data changed outside a read");

  // read of a returns the register as it stood in the wait cycle
  a_read_back_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (read && waitrequest && hitA)
      |=> !waitrequest && (readdata == {READ_PAD, $past(interruptPriorityA_reg)}))
    else $error("read of register a wrong");

  // writes to unmapped places leave both registers alone
  a_unmapped_dropped: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeFire && !hitA && !hitB && !standbySync_reg)
      |=> $stable(interruptPriorityA_reg) && $stable(interruptPriorityB_reg))
    else $error("unmapped write changed a register");

  // a write with lane 0 masked off is dropped
  a_masked_dropped: assert property (
    @(posedge clock) disable iff (!rstn)
    (write && !waitrequest && !lane0 && !standbySync_reg)
      |=> $stable(interruptPriorityA_reg) && $stable(interruptPriorityB_reg))
    else $error("masked write changed a register");

  // without a write or standby register b holds
  a_hold_b: assert property (
    @(posedge clock) disable iff (!rstn)
    (!writeB && !standbySync_reg) |=> $stable(interruptPriorityB_reg))
    else $error("register b changed on its own");

  // first edge after reset release finds both registers clear, bus idle
  a_reset_clears: assert property (
    @(posedge clock)
    $rose(rstn) |-> (interruptPriorityA_reg == PRIO_RESET)
      && (interruptPriorityB_reg == PRIO_RESET) && waitrequest)
    else $error("registers not cleared by reset");

  // level fan-out: a committed write shows on its sources one edge later

  // external line 0 follows bit 7 of a
  a_line0_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeA && !standbySync_reg)
      |=> (prioExtLines[0] == $past(writedata[PRIO_EXT_LINE0_BIT])))
    else $error("external line 0 level wrong");

  // external line 1 follows bit 6 of a
  a_line1_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeA && !standbySync_reg)
      |=> (prioExtLines[1] == $past(writedata[PRIO_EXT_LINE1_BIT])))
    else $error("external line 1 level wrong");

  // external lines 2 and 3 share bit 5 of a
  a_lines23_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeA && !standbySync_reg)
      |=> (prioExtLines[3:2] == {2{$past(writedata[PRIO_EXT_LINES2_3_BIT])}}))
    else $error("external lines 2 and 3 level wrong");

  // external lines 4 and 5 share bit 4 of a
  a_lines45_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeA && !standbySync_reg)
      |=> (prioExtLines[5:4] == {2{$past(writedata[PRIO_EXT_LINES4_5_BIT])}}))
    else $error("external lines 4 and 5 level wrong");

  // watchdog and refresh share bit 3 of a
  a_watchdog_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeA && !standbySync_reg)
      |=> ({prioWatchdog, prioRefresh} == {2{$past(writedata[PRIO_WATCHDOG_REFRESH_BIT])}}))
    else $error("watchdog and refresh level wrong");

  // timer channel 0 follows bit 2 of a
  a_timer0_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeA && !standbySync_reg)
      |=> (prioTimerCh[0] == $past(writedata[PRIO_TIMER_CH0_BIT])))
    else $error("timer channel 0 level wrong");

  // timer channel 1 follows bit 1 of a
  a_timer1_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeA && !standbySync_reg)
      |=> (prioTimerCh[1] == $past(writedata[PRIO_TIMER_CH1_BIT])))
    else $error("timer channel 1 level wrong");

  // timer channel 2 follows bit 0 of a
  a_timer2_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeA && !standbySync_reg)
      |=> (prioTimerCh[2] == $past(writedata[PRIO_TIMER_CH2_BIT])))
    else $error("timer channel 2 level wrong");

  // timer channel 4 follows bit 6 of b
  a_timer4_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeB && !standbySync_reg)
      |=> (prioTimerCh[4] == $past(writedata[PRIO_TIMER_CH4_BIT])))
    else $error("timer channel 4 level wrong");

  // both dma channels share bit 5 of b
  a_dma_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeB && !standbySync_reg)
      |=> (prioDmaCh == {2{$past(writedata[PRIO_DMA_CH0_1_BIT])}}))
    else $error("dma channel level wrong");

  // serial channel 0 follows bit 3 of b
  a_serial0_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeB && !standbySync_reg)
      |=> (prioSerialCh[0] == $past(writedata[PRIO_SERIAL_CH0_BIT])))
    else $error("serial channel 0 level wrong");

  // serial channel 1 follows bit 2 of b
  a_serial1_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeB && !standbySync_reg)
      |=> (prioSerialCh[1] == $past(writedata[PRIO_SERIAL_CH1_BIT])))
    else $error("serial channel 1 level wrong");

  // converter follows bit 1 of b
  a_adc_level: assert property (
    @(posedge clock) disable iff (!rstn)
    (writeB && !standbySync_reg)
      |=> (prioAdc == $past(writedata[PRIO_ADC_BIT])))
    else $error("converter level wrong");

  // a write that changes only spare bits of b moves no level
  a_spare_no_effect: assert property (
    @(posedge clock) disable iff (!rstn)
    (onlySpareB && !standbySync_reg)
      |=> $stable({prioTimerCh[4:3], prioDmaCh, prioSerialCh, prioAdc}))
    else $error("spare bit of register b moved a level");

  // standby forces every source to level 0
  a_standby_levels_low: assert property (
    @(posedge clock) disable iff (!rstn)
    standbySync_reg |=> (allLevels == 18'h00000))
    else $error("levels not cleared in standby");

  // levels stay put unless a write commits or standby clears
  a_levels_steady: assert property (
    @(posedge clock) disable iff (!rstn)
    (!writeA && !writeB && !standbySync_reg)
      |=> $stable(allLevels))
    else $error("levels changed without a write");

endmodule

`default_nettype wire

// *** ips_pkg.sv ***
// constants shared by the interrupt priority select block
package ips_pkg;

  // register index as printed; byte address is four times the index
  localparam logic [15:0] PRIO_A_INDEX = 16'hfff8;
  localparam logic [15:0] PRIO_B_INDEX = 16'hfff9;

  // avalon byte address width and derived byte addresses
  localparam int          ADDR_W       = 18;
  localparam logic [17:0] PRIO_A_ADDR  = {PRIO_A_INDEX, 2'h0};
  localparam logic [17:0] PRIO_B_ADDR  = {PRIO_B_INDEX, 2'h0};

  // register width and reset value of both priority registers
  localparam int         PRIO_W        = 8;
  localparam logic [7:0] PRIO_RESET    = 8'h00;
  localparam logic [23:0] READ_PAD     = 24'h000000;

  // priority level encoding of one field
  localparam logic LEVEL_NONPRIO = 1'h0;
  localparam logic LEVEL_PRIO    = 1'h1;

  // field positions in interrupt_priority_a
  localparam int PRIO_EXT_LINE0_BIT        = 7;
  localparam int PRIO_EXT_LINE1_BIT        = 6;
  localparam int PRIO_EXT_LINES2_3_BIT     = 5;
  localparam int PRIO_EXT_LINES4_5_BIT     = 4;
  localparam int PRIO_WATCHDOG_REFRESH_BIT = 3;
  localparam int PRIO_TIMER_CH0_BIT        = 2;
  localparam int PRIO_TIMER_CH1_BIT        = 1;
  localparam int PRIO_TIMER_CH2_BIT        = 0;

  // field positions in interrupt_priority_b
  localparam int PRIO_TIMER_CH3_BIT        = 7;
  localparam int PRIO_TIMER_CH4_BIT        = 6;
  localparam int PRIO_DMA_CH0_1_BIT        = 5;
  localparam int PRIO_B_SPARE_HI_BIT       = 4;
  localparam int PRIO_SERIAL_CH0_BIT       = 3;
  localparam int PRIO_SERIAL_CH1_BIT       = 2;
  localparam int PRIO_ADC_BIT              = 1;
  localparam int PRIO_B_SPARE_LO_BIT       = 0;

endpackage

// *** interrupt_priority_select_test.sv ***
// self-checking bench for the interrupt priority select block
`timescale 1ns/1ns
`default_nettype none
module interrupt_priority_select_test
  import ips_pkg::*;
  ();
  // bus side and pins driven by the bench
  logic              clock;
  logic              rstn;
  logic              hwStandbyN;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [31:0]       writedata;
  logic [3:0]        byteenable;
  // design outputs
  logic [31:0]       readdata;
  logic              waitrequest;
  logic [5:0]        prioExtLines;
  logic              prioWatchdog;
  logic              prioRefresh;
  logic [4:0]        prioTimerCh;
  logic [1:0]        prioDmaCh;
  logic [1:0]        prioSerialCh;
  logic              prioAdc;
  wire logic [17:0]  levels;       // all level outputs in one word
  int                miscompares;
  int                checked;
  assign levels = {prioExtLines, prioWatchdog, prioRefresh, prioTimerCh, prioDmaCh,
                   prioSerialCh, prioAdc};
  ips_priority_regs DUT (.clock(clock), .rstn(rstn), .hwStandbyN(hwStandbyN),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .prioExtLines(prioExtLines), .prioWatchdog(prioWatchdog), .prioRefresh(prioRefresh),
    .prioTimerCh(prioTimerCh), .prioDmaCh(prioDmaCh), .prioSerialCh(prioSerialCh),
    .prioAdc(prioAdc));
  // 250 MHz clock
  always #2 clock = ~clock;
  // expected levels; spare bits b[4] and b[0] drive nothing
  function automatic logic [17:0] expLevels(input logic [7:0] a, input logic [7:0] b);
    return {a[4], a[4], a[5], a[5], a[6], a[7], a[3], a[3], b[6], b[7], a[0], a[1], a[2],
            b[5], b[5], b[2], b[3], b[1]};
  endfunction
  // verdict and end of run, also reached by a bus timeout
  task automatic end_sim();
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // register word compare, pad bits included
  task automatic cmpWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // level outputs compare
  task automatic cmpLv(input logic [17:0] exp);
    checked++;
    if (levels !== exp) begin
      miscompares++;
      $display("CHECK FAILED levels expected %h seen %h", exp, levels);
    end
  endtask
  // one avalon cycle, held until waitrequest is sampled low
  task automatic busCycle(input logic rd, input logic [17:0] addr, input logic [7:0] wdat,
                          input logic [3:0] be, output logic [31:0] rdat);
    int n;
    @(posedge clock);
    address <= addr;
    read <= rd;
    write <= !rd;
    writedata <= {READ_PAD, wdat};
    byteenable <= be;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'h0 && n < 50);
    if (waitrequest !== 1'h0) begin
      miscompares++;
      end_sim();
    end
    rdat = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task automatic wr(input logic [17:0] addr, input logic [7:0] d);
    logic [31:0] unused;
    busCycle(1'h0, addr, d, 4'h1, unused);
  endtask
  task automatic rdCheck(input string what, input logic [17:0] addr, input logic [7:0] exp);
    logic [31:0] r;
    busCycle(1'h1, addr, 8'h00, 4'h1, r);
    cmpWord(what, {READ_PAD, exp}, r);
  endtask
  // reset values of both registers and of all levels
  task automatic checkReset();
    cmpWord("waitIdle", 32'h00000001, {31'h00000000, waitrequest});
    rdCheck("prioA", PRIO_A_ADDR, PRIO_RESET);
    rdCheck("prioB", PRIO_B_ADDR, PRIO_RESET);
    cmpLv(18'h00000);
  endtask
  // one bit at a time through one register, others left zero
  task automatic walk(input logic selB);
    logic [7:0]  v;
    logic [17:0] exp;
    for (int i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      exp = selB ? expLevels(8'h00, v) : expLevels(v, 8'h00);
      wr(selB ? PRIO_B_ADDR : PRIO_A_ADDR, v);
      rdCheck("walk", selB ? PRIO_B_ADDR : PRIO_A_ADDR, v);
      if (selB) cmpLv(exp);
      else cmpLv(exp);
    end
    wr(selB ? PRIO_B_ADDR : PRIO_A_ADDR, 8'h00);
  endtask
  // full patterns, unmapped place and masked lane
  task automatic checkRefused();
    logic [31:0] unused;
    wr(PRIO_A_ADDR, 8'ha5);
    wr(PRIO_B_ADDR, 8'h5a);
    rdCheck("prioA", PRIO_A_ADDR, 8'ha5);
    rdCheck("prioB", PRIO_B_ADDR, 8'h5a);
    cmpLv(expLevels(8'ha5, 8'h5a));
    wr(18'h3ffe8, 8'hff);
    rdCheck("unmapped", 18'h3ffe8, 8'h00);
    busCycle(1'h0, PRIO_A_ADDR, 8'h3c, 4'he, unused);
    rdCheck("masked", PRIO_A_ADDR, 8'ha5);
  endtask
  // standby clears both registers and loses writes made meanwhile
  task automatic checkStandby();
    wr(PRIO_A_ADDR, 8'hff);
    wr(PRIO_B_ADDR, 8'hff);
    @(posedge clock);
    hwStandbyN <= 1'h0;
    repeat (4) @(posedge clock);
    cmpLv(18'h00000);
    wr(PRIO_A_ADDR, 8'h81);
    @(posedge clock);
    hwStandbyN <= 1'h1;
    repeat (4) @(posedge clock);
    rdCheck("stbyA", PRIO_A_ADDR, 8'h00);
    rdCheck("stbyB", PRIO_B_ADDR, 8'h00);
  endtask
  // reset in mid-run clears registers that hold ones
  task automatic checkMidReset();
    wr(PRIO_A_ADDR, 8'h5a);
    wr(PRIO_B_ADDR, 8'ha5);
    @(posedge clock);
    rstn <= 1'h0;
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    checkReset();
  endtask
  // main sequence
  initial begin
    clock = 1'h0;
    rstn = 1'h0;
    hwStandbyN = 1'h1;
    address = 18'h00000;
    read = 1'h0;
    write = 1'h0;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    miscompares = 0;
    checked = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    checkReset();
    walk(1'h0);
    walk(1'h1);
    checkRefused();
    checkStandby();
    checkMidReset();
    end_sim();
  end
endmodule
`default_nettype wire
